// >>> fan_pwm_pkg.sv
// Register map, field layout and timing constants for the second fan PWM channel.
package fan_pwm_pkg;
    // Register indices as printed; byte address is four times the index.
    localparam logic [7:0] CTRL_IDX = 8'h00_CF;
    localparam logic [7:0] BASE1_IDX = 8'h00_D0;
    localparam logic [7:0] BASE2_IDX = 8'h00_D1;
    localparam logic [7:0] BASE3_IDX = 8'h00_D2;
    localparam logic [7:0] BASE4_IDX = 8'h00_D3;
    localparam logic [7:0] STEP_REQ_IDX = 8'h00_C0;
    localparam logic [7:0] STATUS_IDX = 8'h00_C1;
    localparam int ADDR_W = 12;
    localparam int TABLES = 4;
    localparam logic [7:0] CTRL_RESET = 8'h00_00;
    localparam logic [7:0] BASE_RESET = 8'h00_00;
    localparam logic [7:0] CTRL_WMASK = 8'h00_0F;
    localparam int FREQ_LSB = 0;
    localparam int FREQ_MSB = 2;
    localparam int MAP_BIT = 3;
    localparam logic [2:0] FREQ_HIGH = 3'h0;
    localparam int CLK_HZ = 20_000_000;
    // Duty resolution: one PWM period is DUTY_FULL counts of the duty counter.
    localparam logic [9:0] DUTY_FULL = 10'h0_380;
    localparam logic [3:0] STEP_MAX = 4'hD;
    localparam logic [3:0] STEP_OFF = 4'h0;
    localparam logic [3:0] STEP_FIRST = 4'h1;
    // Both maps start at a quarter of full scale.
    localparam logic [9:0] DUTY_BASE = 10'h0_0E0;
    // Fine map adds one sixteenth of full scale per step.
    localparam logic [9:0] FINE_INC = 10'h0_038;
    // Coarse map adds one twenty-eighth of full scale per step up to its last linear step.
    localparam logic [9:0] COARSE_INC = 10'h0_020;
    localparam logic [3:0] COARSE_LAST = 4'hA;
    localparam logic [3:0] STEP_ELEVEN = 4'hB;
    localparam logic [9:0] DUTY_STEP11 = 10'h0_280;
    localparam logic [9:0] DUTY_STEP12 = 10'h0_300;
    // Output frequency per select code, in Hz.
    localparam int FREQ_HZ [8] = '{22500, 96, 84, 72, 60, 48, 36, 12};
    localparam int PRESCALE_BITS = 8;
endpackage

// >>> duty_map.sv
`timescale 1ns/1ps
// Step-to-duty lookup for the two duty-cycle maps.
module duty_map (
    // Selection
    input wire logic [3:0] step,
    input wire logic use_fine_map,
    // Result in counts out of the full scale
    output logic [9:0] duty
);
    import fan_pwm_pkg::*;

    // Fine map: 25% + 6.25% per step (896 counts: 224 + 56 per step).
    // Coarse map: 25% + 1/28 per step to step 10, then 5/7, 6/7, 1 (32 per 28th).
    always_comb begin
        duty = 10'h0_000;
        if (step == STEP_OFF) begin
            duty = 10'h0_000;
        end else if (step >= STEP_MAX) begin
            duty = DUTY_FULL;
        end else if (use_fine_map) begin
            duty = 10'(DUTY_BASE + FINE_INC * 10'(step - STEP_FIRST));
        end else if (step <= COARSE_LAST) begin
            duty = 10'(DUTY_BASE + COARSE_INC * 10'(step - STEP_FIRST));
        end else if (step == STEP_ELEVEN) begin
            duty = DUTY_STEP11;
        end else begin
            duty = DUTY_STEP12;
        end
    end
endmodule

// >>> pwm_counter.sv
`timescale 1ns/1ps
// Free-running PWM period counter with a per-frequency prescaler.
module pwm_counter (
    // Clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // Frequency select
    input wire logic [2:0] freq_sel,
    // Position in the current period
    output logic [9:0] phase
);
    import fan_pwm_pkg::*;

    logic [15:0] pre_reg;
    logic [15:0] pre_limit;

    // Each phase count lasts CLK_HZ / (FREQ * DUTY_FULL) clocks, at least one.
    always_comb begin
        pre_limit = 16'(CLK_HZ / (FREQ_HZ[freq_sel] * int'(DUTY_FULL)));
        if (pre_limit == 16'h0000) begin
            pre_limit = 16'h0001;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pre_reg <= 16'h0000;
            phase <= 10'h0_000;
        end else if (pre_reg + 16'h0001 >= pre_limit) begin
            pre_reg <= 16'h0000;
            phase <= (phase + 10'h0_001 >= DUTY_FULL) ? 10'h0_000 : phase + 10'h0_001;
        end else begin
            pre_reg <= pre_reg + 16'h0001;
        end
    end
endmodule

// >>> fan_pwm_freq_and_duty_map.sv
`timescale 1ns/1ps
// APB register block and PWM output for the second fan channel.

module fan_pwm_freq_and_duty_map (
    // APB
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [fan_pwm_pkg::ADDR_W-1:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [3:0] pstrb,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // Fan stage
    output logic second_fan_pwm_output,
    // Base temperatures to the comparison logic
    output logic [7:0] table1_base_temperature,
    output logic [7:0] table2_base_temperature,
    output logic [7:0] table3_base_temperature,
    output logic [7:0] table4_base_temperature,
    // Coarse/fine map choice shared with other stepped sources
    output logic fine_map_active
);
    import fan_pwm_pkg::*;

    logic [7:0] ctrl_reg;
    logic [7:0] base_reg [TABLES];
    logic [3:0] step_reg;
    logic [9:0] duty;
    logic [9:0] phase;
    logic [9:0] phase_prev_reg;
    logic [9:0] duty_latched_reg;
    logic access;
    logic [9:0] idx;
    logic mapped;
    logic [31:0] rdata_next;

    assign access = psel && penable;
    assign idx = paddr[ADDR_W-1:2];

    always_comb begin
        mapped = 1'b1;
        rdata_next = 32'h0000_0000;
        case (idx[7:0])
            CTRL_IDX: rdata_next = {24'h00_0000, ctrl_reg & CTRL_WMASK};
            BASE1_IDX: rdata_next = {24'h00_0000, base_reg[0]};
            BASE2_IDX: rdata_next = {24'h00_0000, base_reg[1]};
            BASE3_IDX: rdata_next = {24'h00_0000, base_reg[2]};
            BASE4_IDX: rdata_next = {24'h00_0000, base_reg[3]};
            STEP_REQ_IDX: rdata_next = {28'h000_0000, step_reg};
            STATUS_IDX: rdata_next = {21'h00_0000, fine_map_active, duty_latched_reg};
            default: mapped = 1'b0;
        endcase
        if (idx[9:8] != 2'b00) begin
            mapped = 1'b0;
            rdata_next = 32'h0000_0000;
        end
    end

    // Zero-wait slave: pready is high throughout every access phase.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready <= 1'b0;
            pslverr <= 1'b0;
            prdata <= 32'h0000_0000;
        end else begin
            pready <= psel && !penable;
            pslverr <= psel && !penable && !mapped;
            prdata <= (psel && !penable && !pwrite) ? rdata_next : 32'h0000_0000;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ctrl_reg <= CTRL_RESET;
        end else if (access && pwrite && pstrb[0] && idx == {2'b00, CTRL_IDX}) begin
            ctrl_reg <= pwdata[7:0] & CTRL_WMASK;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            step_reg <= STEP_OFF;
        end else if (access && pwrite && pstrb[0] && idx == {2'b00, STEP_REQ_IDX}) begin
            step_reg <= (pwdata[3:0] > STEP_MAX) ? STEP_MAX : pwdata[3:0];
        end
    end

    genvar g;
    generate
        for (g = 0; g < TABLES; g++) begin : g_base
            always_ff @(posedge pclk or negedge presetn) begin
                if (!presetn) begin
                    base_reg[g] <= BASE_RESET;
                end else if (access && pwrite && pstrb[0]
                             && idx == {2'b00, BASE1_IDX + 8'(g)}) begin
                    base_reg[g] <= pwdata[7:0];
                end
            end
        end
    endgenerate

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            table1_base_temperature <= BASE_RESET;
            table2_base_temperature <= BASE_RESET;
            table3_base_temperature <= BASE_RESET;
            table4_base_temperature <= BASE_RESET;
        end else begin
            table1_base_temperature <= base_reg[0];
            table2_base_temperature <= base_reg[1];
            table3_base_temperature <= base_reg[2];
            table4_base_temperature <= base_reg[3];
        end
    end

    // selector honoured only at high frequency
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            fine_map_active <= 1'b0;
        end else begin
            fine_map_active <= (ctrl_reg[FREQ_MSB:FREQ_LSB] == FREQ_HIGH) && !ctrl_reg[MAP_BIT];
        end
    end

    // one map for all stepped sources
    duty_map u_map (
        .step(step_reg),
        .use_fine_map(fine_map_active),
        .duty(duty)
    );

    pwm_counter u_cnt (
        .pclk(pclk),
        .presetn(presetn),
        .freq_sel(ctrl_reg[FREQ_MSB:FREQ_LSB]),
        .phase(phase)
    );

    // New duty is latched at a period boundary, but the first clock of each period still uses the old duty, so a drop to zero gives a one-clock pulse.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            phase_prev_reg <= 10'h0_000;
            duty_latched_reg <= 10'h0_000;
        end else begin
            phase_prev_reg <= phase;
            if (phase == 10'h0_000 && phase_prev_reg != 10'h0_000) begin
                duty_latched_reg <= duty;
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            second_fan_pwm_output <= 1'b0;
        end else begin
            second_fan_pwm_output <= (phase < duty_latched_reg);
        end
    end
endmodule

// >>> fan_pwm_freq_and_duty_map_chk.sv
`timescale 1ns/1ps
// Port checker for the second fan PWM register block.
module fan_pwm_freq_and_duty_map_chk (
    // APB
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [fan_pwm_pkg::ADDR_W-1:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [3:0] pstrb,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    // Block outputs
    input wire logic second_fan_pwm_output,
    input wire logic [7:0] table1_base_temperature,
    input wire logic [7:0] table2_base_temperature,
    input wire logic [7:0] table3_base_temperature,
    input wire logic [7:0] table4_base_temperature,
    input wire logic fine_map_active
);
    import fan_pwm_pkg::*;
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);
    logic [3:0] ctrl_q;
    logic [7:0] b1_q, b4_q;
    logic [1:0] quiet;
    wire wr = psel && penable && pready && pwrite && pstrb[0];
    wire rd = psel && penable && pready && !pwrite;
    // Registered copies may lag a write, so outputs are judged only after three quiet edges.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ctrl_q <= 4'h0;
            b1_q <= 8'h00;
            b4_q <= 8'h00;
            quiet <= 2'h0;
        end else begin
            quiet <= wr ? 2'h0 : quiet + 2'(quiet != 2'h3);
            if (wr && paddr == 12'h33C) ctrl_q <= pwdata[3:0];
            if (wr && paddr == 12'h340) b1_q <= pwdata[7:0];
            if (wr && paddr == 12'h34C) b4_q <= pwdata[7:0];
        end
    end
    ctrl_read_a: assert property (rd && paddr == 12'h33C |-> prdata[3:0] == ctrl_q)
        else $error("control read wrong");
    rsvd_zero_a: assert property (rd && paddr == 12'h33C |-> prdata[31:4] == '0)
        else $error("reserved bits not zero");
    map_gate_a: assert property (quiet == 2'h3 && ctrl_q[2:0] == 3'h0
        |-> fine_map_active == !ctrl_q[3]) else $error("map select ignored");
    coarse_force_a: assert property (quiet == 2'h3 && ctrl_q[2:0] != 3'h0
        |-> !fine_map_active) else $error("fine map at low rate");
    status_map_a: assert property (rd && paddr == 12'h304 && $stable(fine_map_active)
        |-> prdata[10] == fine_map_active) else $error("status map bit wrong");
    base_hold_a: assert property (quiet == 2'h3 |-> table1_base_temperature == b1_q)
        else $error("base one port wrong");
    base4_hold_a: assert property (quiet == 2'h3 |-> table4_base_temperature == b4_q)
        else $error("base four port wrong");
    base_read_a: assert property (rd && paddr == 12'h340 |-> prdata == {24'h0, b1_q})
        else $error("base one read wrong");
    cover property (wr && paddr == 12'h33C);
    cover property (rd && pslverr);
    cover property ($rose(fine_map_active));
endmodule

bind fan_pwm_freq_and_duty_map fan_pwm_freq_and_duty_map_chk chk_u (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .second_fan_pwm_output(second_fan_pwm_output),
    .table1_base_temperature(table1_base_temperature),
    .table2_base_temperature(table2_base_temperature),
    .table3_base_temperature(table3_base_temperature),
    .table4_base_temperature(table4_base_temperature),
    .fine_map_active(fine_map_active)
);

// >>> fan_stage_model.sv
`timescale 1ns/1ps
// Fan stage stand-in: measures high time and period of the PWM drive.
module fan_stage_model (
    // Drive from the block
    input wire logic pclk,
    input wire logic pwm,
    // Last whole period, in clocks
    output int hi,
    output int per
);
    int h = 0;
    int p = 0;
    logic last = 1'b0;
    always @(posedge pclk) begin
        last <= pwm;
        if (pwm && !last) begin
            hi <= h;
            per <= p;
            h <= 1;
            p <= 1;
        end else begin
            h <= h + int'(pwm);
            p <= p + 1;
        end
    end
endmodule

// >>> test_fan_pwm_freq_and_duty_map.sv
`timescale 1ns/1ps
// Self-checking bench for the second fan PWM register block.
module test_fan_pwm_freq_and_duty_map;
    import fan_pwm_pkg::*;
    logic pclk = 1'b0;
    logic presetn = 1'b0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [ADDR_W-1:0] paddr = '0;
    logic [31:0] pwdata = '0;
    logic [3:0] pstrb = 4'h0;
    logic [31:0] prdata, rd;
    logic pready, pslverr, pwm, fine, err;
    logic [7:0] tt [4];
    int hi, per, miscompares = 0, n_checks = 0, cyc = 0;
    always #25 pclk = ~pclk;
    fan_pwm_freq_and_duty_map dut_u (
        .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .second_fan_pwm_output(pwm),
        .table1_base_temperature(tt[0]), .table2_base_temperature(tt[1]),
        .table3_base_temperature(tt[2]), .table4_base_temperature(tt[3]),
        .fine_map_active(fine)
    );
    fan_stage_model stage_u (.pclk(pclk), .pwm(pwm), .hi(hi), .per(per));
    task automatic close_out();
        $display("checks %0d mismatches %0d", n_checks, miscompares);
        if (miscompares == 0 && n_checks > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask
    always @(posedge pclk) begin
        cyc++;
        if (cyc == 60000) begin
            miscompares++;
            close_out();
        end
    end
    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        n_checks++;
        if (got !== exp) begin
            miscompares++;
            $display("[FAIL] %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        pstrb <= w ? 4'h1 : 4'h0;
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
    endtask
    function automatic int exp_duty(input logic f, input int k);
        if (k >= 13) return 896;
        if (f) return 224 + 56 * (k - 1);
        if (k <= 10) return 224 + 32 * (k - 1);
        return 512 + 128 * (k - 10);
    endfunction
    task automatic t_regs();
        for (int i = 0; i < 5; i++) begin
            apb(1'b0, 12'h33C + 12'(4 * i), 32'h0);
            chk("reset value", 32'h0, rd);
        end
        for (int i = 0; i < 4; i++) apb(1'b1, 12'h340 + 12'(4 * i), 32'h7F + i);
        for (int i = 0; i < 4; i++) begin
            apb(1'b0, 12'h340 + 12'(4 * i), 32'h0);
            chk("base read", 32'h7F + i, rd);
            chk("base port", 32'h7F + i, tt[i]);
        end
        apb(1'b1, 12'h004, 32'h5A);
        chk("unmapped err", 32'h1, err);
        $display("register test done");
    endtask
    task automatic t_ctrl();
        for (int c = 0; c < 16; c++) begin
            apb(1'b1, 12'h33C, 32'hFFFF_FFF0 | c);
            apb(1'b0, 12'h33C, 32'h0);
            chk("control", c, rd);
            chk("fine map", c == 0, fine);
        end
        $display("control test done");
    endtask
    task automatic t_duty(input logic [7:0] c, input int k);
        int lows;
        lows = 0;
        apb(1'b1, 12'h33C, {24'h0, c});
        apb(1'b1, 12'h300, k);
        repeat (3000) @(posedge pclk);
        apb(1'b0, 12'h304, 32'h0);
        chk("status duty", exp_duty(c == 0, k), rd[9:0]);
        chk("status map", 32'(c == 0), rd[10]);
        if (k >= 13) begin
            repeat (900) @(posedge pclk) lows += int'(pwm !== 1'b1);
            chk("full duty lows", 32'h0, lows);
        end else begin
            chk("high time", exp_duty(c == 0, k), hi);
            chk("period", 32'd896, per);
        end
        $display("duty test ctrl %h step %0d done", c, k);
    endtask
    initial begin
        repeat (4) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        t_regs();
        t_ctrl();
        for (int m = 0; m < 2; m++) begin
            t_duty(8'(8 * m), 1);
            t_duty(8'(8 * m), 10);
            t_duty(8'(8 * m), 11);
            t_duty(8'(8 * m), 12);
            t_duty(8'(8 * m), 13);
        end
        t_duty(8'h00, 15);
        close_out();
    end
endmodule
